// File: logic/i2ccfg_target.v
// Purpose: two-wire target port for the configuration memory
// Assumes: clk well above 8x serial clock; open-drain data line
// Notes: memory is an internal array, also reachable on cfgRdAddr
`include "i2ccfg_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module i2ccfg_target
(
  input wire clk,
  input wire rst,
  input wire serialClockIn,
  input wire serialDataIn,
  output reg serialDataOut,
  output reg serialDataOe,
  input wire [6:0] devAddr,
  input wire [`I2CCFG_ADDR_W-1:0] cfgRdAddr,
  output reg [`I2CCFG_DATA_W-1:0] cfgRdData,
  output reg cfgWrStrobe,
  output reg [`I2CCFG_ADDR_W-1:0] memoryAddressPointer,
  output reg busy
);
  localparam ST_IDLE = 3'h0;
  localparam ST_DEVADR = 3'h1;
  localparam ST_DEVACK = 3'h2;
  localparam ST_WRBYTE = 3'h3;
  localparam ST_WRACK = 3'h4;
  localparam ST_RDBYTE = 3'h5;
  localparam ST_RDACK = 3'h6;
  localparam ST_SKIP = 3'h7;

  reg [`I2CCFG_DATA_W-1:0] mem [0:`I2CCFG_MEM_DEPTH-1];
  wire sclS;
  wire sdaS;
  reg sclD;
  reg sdaD;
  reg [2:0] state;
  reg [3:0] bitCnt;
  reg [7:0] shiftReg;
  reg haveAddr;
  reg readDir;

  i2ccfg_sync uSyncScl
  (
    .clk(clk),
    .rst(rst),
    .asyncIn(serialClockIn),
    .syncOut(sclS)
  );
  i2ccfg_sync uSyncSda
  (
    .clk(clk),
    .rst(rst),
    .asyncIn(serialDataIn),
    .syncOut(sdaS)
  );

  // edge and bus-condition detection on synchronised lines
  wire sclRise = sclS & ~sclD;
  wire sclFall = ~sclS & sclD;
  wire startCond = sclS & sclD & sdaD & ~sdaS;
  wire stopCond = sclS & sclD & ~sdaD & sdaS;

  always @(posedge clk)
  begin
    cfgRdData <= mem[cfgRdAddr];
  end

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sclD <= 1'b1;
      sdaD <= 1'b1;
      state <= ST_IDLE;
      bitCnt <= 4'h0;
      shiftReg <= 8'h00;
      haveAddr <= 1'b0;
      readDir <= 1'b0;
      serialDataOut <= 1'b0;
      serialDataOe <= 1'b0;
      cfgWrStrobe <= 1'b0;
      memoryAddressPointer <= 8'h00;
      busy <= 1'b0;
    end
    else
    begin
      sclD <= sclS;
      sdaD <= sdaS;
      cfgWrStrobe <= 1'b0;
      serialDataOut <= 1'b0;
      if (startCond)
      begin
        // repeated start keeps the pointer, stores nothing
        state <= ST_DEVADR;
        bitCnt <= 4'h0;
        serialDataOe <= 1'b0;
        busy <= 1'b1;
      end
      else if (stopCond)
      begin
        // stop ends any transfer and releases data
        state <= ST_IDLE;
        serialDataOe <= 1'b0;
        busy <= 1'b0;
      end
      else
      begin
        case (state)
          ST_IDLE:
          begin
            serialDataOe <= 1'b0;
          end
          ST_DEVADR:
          begin
            if (sclRise)
            begin
              shiftReg <= {shiftReg[6:0], sdaS};
              bitCnt <= bitCnt + 4'h1;
            end
            else if (sclFall && bitCnt == 4'h8)
            begin
              bitCnt <= 4'h0;
              readDir <= shiftReg[0];
              if (shiftReg[7:1] == devAddr)
              begin
                // address ack drives data low
                serialDataOe <= 1'b1;
                state <= ST_DEVACK;
              end
              else
              begin
                state <= ST_SKIP;
              end
            end
          end
          ST_DEVACK:
          begin
            if (sclFall)
            begin
              if (readDir)
              begin
                // first read byte from pointer
                shiftReg <= mem[memoryAddressPointer];
                serialDataOe <= ~mem[memoryAddressPointer][7];
                state <= ST_RDBYTE;
              end
              else
              begin
                serialDataOe <= 1'b0;
                haveAddr <= 1'b0;
                state <= ST_WRBYTE;
              end
            end
          end
          ST_WRBYTE:
          begin
            if (sclRise)
            begin
              shiftReg <= {shiftReg[6:0], sdaS};
              bitCnt <= bitCnt + 4'h1;
            end
            else if (sclFall && bitCnt == 4'h8)
            begin
              bitCnt <= 4'h0;
              serialDataOe <= 1'b1;
              state <= ST_WRACK;
              if (!haveAddr)
              begin
                memoryAddressPointer <= shiftReg;
                haveAddr <= 1'b1;
              end
              else
              begin
                mem[memoryAddressPointer] <= shiftReg;
                cfgWrStrobe <= 1'b1;
                // consecutive locations per byte
                memoryAddressPointer <= memoryAddressPointer + 8'h01;
              end
            end
          end
          ST_WRACK:
          begin
            if (sclFall)
            begin
              serialDataOe <= 1'b0;
              state <= ST_WRBYTE;
            end
          end
          ST_RDBYTE:
          begin
            if (sclFall)
            begin
              if (bitCnt == 4'h7)
              begin
                bitCnt <= 4'h0;
                serialDataOe <= 1'b0;
                state <= ST_RDACK;
              end
              else
              begin
                bitCnt <= bitCnt + 4'h1;
                shiftReg <= {shiftReg[6:0], 1'b0};
                serialDataOe <= ~shiftReg[6];
              end
            end
          end
          ST_RDACK:
          begin
            if (sclRise)
            begin
              if (sdaS)
              begin
                state <= ST_SKIP;
              end
              else
              begin
                // master ack advances pointer
                memoryAddressPointer <= memoryAddressPointer + 8'h01;
                shiftReg <= mem[memoryAddressPointer + 8'h01];
                state <= ST_DEVACK;
              end
            end
          end
          ST_SKIP:
          begin
            serialDataOe <= 1'b0;
          end
          default:
          begin
            state <= ST_IDLE;
          end
        endcase
        // resume read shifting after master ack
        if (state == ST_RDACK && sclRise && !sdaS)
        begin
          readDir <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: logic/i2ccfg_regs.vh
// Purpose: constants for the two-wire configuration target port
// Assumes: 20 MHz system clock, serial clock up to 400 kb/s
// Notes: memory is 256 bytes behind an 8-bit address pointer
// Overview of operation
// - The port carries reads and writes at up to 400 kb/s on a two-wire bus.
// - A write is START, 7-bit address, direction, ack, 8-bit address, ack, data bytes each acked.
// - Each further write data byte lands at the next consecutive memory address until STOP.
// - After the address word the master sends an 8-bit register address, which the port acks low.
// - Every received data byte is acked low, and the master ends a write with STOP.
// - A random read writes only the word address then repeats START, loading the pointer without storing data.
// - On a read-direction address byte the port acks and shifts out the byte at the pointer.
// - The master ends a read with no-ack and STOP, after which the port stops driving data.
// - Each master ack after a read byte increments the pointer and sends the next byte.
// - The port answers a programmable 7-bit bus address on devAddr; it does not use the 69 hex I2CCFG_DEV_ADDR_DEFAULT.
`ifndef I2CCFG_REGS_VH
`define I2CCFG_REGS_VH
`define I2CCFG_DEV_ADDR_DEFAULT 7'h69
`define I2CCFG_ADDR_W 8
`define I2CCFG_DATA_W 8
`define I2CCFG_MEM_DEPTH 256
`define I2CCFG_BIT_RATE_KBPS 400
`endif

// File: logic/i2ccfg_sync.v
// Purpose: two-flop synchroniser for one level
// Assumes: input is asynchronous to clk
// Notes: first stage is read only by the second
`timescale 1ns/1ps
`default_nettype none
module i2ccfg_sync
(
  input wire clk,
  input wire rst,
  input wire asyncIn,
  output reg syncOut
);
  reg stage1;
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      stage1 <= 1'b1;
      syncOut <= 1'b1;
    end
    else
    begin
      stage1 <= asyncIn;
      syncOut <= stage1;
    end
  end
endmodule
`default_nettype wire

// File: tb/i2ccfg_chk.sv
// Purpose: port checks on the two-wire target
// Assumes: bound into i2ccfg_target
// Notes: one clock domain
`timescale 1ns/1ps
`default_nettype none
module i2ccfg_chk
(
  input wire logic clk,
  input wire logic rst,
  input wire logic serialClockIn,
  input wire logic serialDataIn,
  input wire logic serialDataOut,
  input wire logic serialDataOe,
  input wire logic cfgWrStrobe,
  input wire logic busy
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  property p_lowOnly; serialDataOe |-> !serialDataOut; endproperty
  a_lowOnly: assert property (p_lowOnly)
    else $error("data line driven high");
  property p_steady;
    serialClockIn && $past(serialClockIn) |-> $stable(serialDataOe);
  endproperty
  a_steady: assert property (p_steady)
    else $error("data moved while clock high");
  property p_ackLow; $rose(serialDataOe) |-> !serialClockIn; endproperty
  a_ackLow: assert property (p_ackLow)
    else $error("drive began in clock high");
  property p_ackHold; $rose(serialDataOe) |-> serialDataOe [*6]; endproperty
  a_ackHold: assert property (p_ackHold)
    else $error("ack too short");
  property p_idle; !busy |-> !serialDataOe; endproperty
  a_idle: assert property (p_idle)
    else $error("drive outside transfer");
  property p_pulse; cfgWrStrobe |=> !cfgWrStrobe; endproperty
  a_pulse: assert property (p_pulse)
    else $error("store strobe too long");
  property p_inXfer; cfgWrStrobe |-> busy; endproperty
  a_inXfer: assert property (p_inXfer)
    else $error("store outside transfer");
  property p_stop; $fell(busy) |-> serialDataIn && serialClockIn; endproperty
  a_stop: assert property (p_stop)
    else $error("end without stop");
endmodule
bind i2ccfg_target i2ccfg_chk chk_u(.clk(clk), .rst(rst),
  .serialClockIn(serialClockIn), .serialDataIn(serialDataIn),
  .serialDataOut(serialDataOut), .serialDataOe(serialDataOe),
  .cfgWrStrobe(cfgWrStrobe), .busy(busy));
`default_nettype wire

// File: tb/i2ccfg_master.sv
// Purpose: behavioural two-wire bus master
// Assumes: data line has a pull-up
// Notes: clock stays high between frames
`timescale 1ns/1ps
`default_nettype none
module i2ccfg_master
(
  output logic scl,
  output logic sdaLow,
  input wire logic sda,
  output logic [8:0] res,
  output logic resOk
);
  localparam int Q = 200;
  initial {scl, sdaLow, resOk, res} = 12'h800;
  task automatic start();
    #Q sdaLow = 0;
    #Q scl = 1;
    #Q sdaLow = 1;
    #Q scl = 0;
  endtask
  task automatic stop();
    #Q sdaLow = 1;
    #Q scl = 1;
    #Q sdaLow = 0;
    #Q;
  endtask
  // each bit 800 ns, phases long enough for the synchroniser
  task automatic xfer(input logic [7:0] b, input logic rd, input logic ack);
    logic [8:0] w;
    w = rd ? {8'hFF, !ack} : {b, 1'b1};
    for (int i = 8; i >= 0; i--)
    begin
      #Q sdaLow = !w[i];
      #Q scl = 1;
      #Q res[i] = sda;
      #Q scl = 0;
    end
    resOk = !resOk;
  endtask
endmodule
`default_nettype wire

// File: tb/i2ccfg_target_tb_top.sv
// Purpose: self-checking bench for i2ccfg_target
// Assumes: master model on the serial side
// Notes: results are {line byte, ack bit}
`timescale 1ns/1ps
`default_nettype none
module i2ccfg_target_tb_top;
  logic clk = 0;
  logic rst = 1;
  logic [6:0] devAddr = 7'h69;
  logic [7:0] cfgRdData, ptr, d, a;
  logic sdaOut, sdaOe, strobe, busy, scl, mLow, resOk;
  logic [8:0] res;
  logic [7:0] mem [256];
  logic [8:0] expQ [$];
  int fail_count = 0;
  int checks_done = 0;
  int seed = 29;
  int stores = 0;
  logic [7:0] rdAddr = 8'h00;
  wire sda = !(sdaOe || mLow);
  always #25 clk = !clk;
  i2ccfg_target dut_u(.clk(clk), .rst(rst), .serialClockIn(scl),
    .serialDataIn(sda), .serialDataOut(sdaOut), .serialDataOe(sdaOe),
    .devAddr(devAddr), .cfgRdAddr(rdAddr), .cfgRdData(cfgRdData),
    .cfgWrStrobe(strobe), .memoryAddressPointer(ptr), .busy(busy));
  i2ccfg_master m(.scl(scl), .sdaLow(mLow), .sda(sda), .res(res),
    .resOk(resOk));
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic tx(input logic [7:0] b, input logic rd,
    input logic [7:0] ed, input logic ea);
    expQ.push_back({ed, ea});
    m.xfer(b, rd, !ea);
  endtask
  task automatic adr(input logic rd);
    tx({devAddr, rd}, 0, {devAddr, rd}, 0);
  endtask
  always @(resOk)
    if (!rst)
    begin
      checks_done++;
      if (res !== expQ[0])
      begin
        fail_count++;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, res, expQ[0]);
      end
      expQ.pop_front();
    end
  always @(posedge clk)
    if (!rst && strobe)
      stores++;
  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    end_of_test();
  end
  initial
  begin
    repeat (20) @(posedge clk);
    #1 rst = 0;
    repeat (3) @(posedge clk);
    #1 m.start();
    adr(0);
    tx(8'hFE, 0, 8'hFE, 0);
    a = 8'hFE;
    for (int i = 0; i < 3; i++)
    begin
      mem[a] = 8'($random(seed));
      tx(mem[a], 0, mem[a], 0);
      a++;
    end
    m.stop();
    m.start();
    adr(0);
    tx(8'hFE, 0, 8'hFE, 0);
    m.start();
    adr(1);
    a = 8'hFE;
    for (int i = 0; i < 3; i++)
    begin
      tx(8'hFF, 1, mem[a], i == 2);
      a++;
    end
    m.stop();
    devAddr = 7'($random(seed));
    m.start();
    tx({devAddr ^ 7'h01, 1'b0}, 0, {devAddr ^ 7'h01, 1'b0}, 1);
    m.stop();
    m.start();
    adr(0);
    tx(8'hFF, 0, 8'hFF, 0);
    m.start();
    adr(1);
    tx(8'hFF, 1, mem[8'hFF], 1);
    m.stop();
    // side read port must show what the serial writes stored
    for (int i = 0; i < 3; i++)
    begin
      #1 rdAddr = 8'hFE + 8'(i);
      repeat (2) @(posedge clk);
      #1 checks_done++;
      if (cfgRdData !== mem[rdAddr])
      begin
        fail_count++;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, cfgRdData,
          mem[rdAddr]);
      end
    end
    checks_done++;
    if (ptr !== 8'hFF)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, ptr, 8'hFF);
    end
    checks_done++;
    if (stores !== 3)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, stores, 3);
    end
    end_of_test();
  end
endmodule
`default_nettype wire
